// ---- rtl/dfp_core.sv ----
`timescale 1ns/1ps

// What this block does
// - each of the two channels has its own detection and shutdown path.
// - a confirmed short switches that channel off, and reports at once if no report pulse is already running.
// - after a short shutdown the command is ignored for a blocking time.
// - detection is masked for about 3 us after every turn-on.
// - a short needs the desat comparator high for about 1 us unbroken.
// - filtering starts only once both blanking and threshold are past.
// - the response from turn-on to shutdown is never under 4 us.
// - while commanded off, the collector sense pin is clamped to the rail.
// - a desaturation fault turns the gate off through the gradual path.
// - ordinary turn-off never uses the gradual path.
// - fault type is the low pulse length: 10, 20, 40 or 80 ms.
// - primary undervoltage holds both channels off and flags both.
// - secondary undervoltage blocks and flags its own channel.
// - status outputs release by themselves once undervoltage clears.
module dfp_core #(
  parameter int unsigned BLOCK_CYC   = dfp_pkg::BLOCK_CYC_DEF,
  parameter int unsigned RET_SC_CYC  = dfp_pkg::RET_SC_CYC_DEF,
  parameter int unsigned RET_UVS_CYC = dfp_pkg::RET_UVS_CYC_DEF,
  parameter int unsigned RET_UVP_CYC = dfp_pkg::RET_UVP_CYC_DEF,
  parameter int unsigned RET_OTH_CYC = dfp_pkg::RET_OTH_CYC_DEF
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    srst_i,
  // host commands, asynchronous
  input  wire logic [dfp_pkg::NCH-1:0] cmd_i,
  // analog monitors, asynchronous
  input  wire logic [dfp_pkg::NCH-1:0] desat_i,
  input  wire logic                    uv_pri_i,
  input  wire logic [dfp_pkg::NCH-1:0] uv_sec_i,
  input  wire logic [dfp_pkg::NCH-1:0] other_fault_i,
  // gate stage controls
  input  wire logic                    unused_tie_i,
  output logic      [dfp_pkg::NCH-1:0] gate_on_o,
  output logic      [dfp_pkg::NCH-1:0] gradual_turn_off_o,
  output logic      [dfp_pkg::NCH-1:0] collector_clamp_o,
  // fault status to host, low while reporting
  output logic      [dfp_pkg::NCH-1:0] fault_status_output_n_o
);
  import dfp_pkg::*;

  localparam logic [TMR_W-1:0] BLOCK_LAST = TMR_W'(BLOCK_CYC - 1);

  dfp_state_t s_q;
  dfp_state_t s_d;

  // ----------------------------------------------------------------------
  // decoders
  // ----------------------------------------------------------------------
  // lowest index wins: short, secondary, primary, other
  function automatic dfp_kind_t dfp_pick(input logic [3:0] p);
    dfp_pick = DFP_K_OTH;
    for (int i = 3; i >= 0; i--) begin
      if (p[i]) begin
        dfp_pick = dfp_kind_t'(i[1:0]);
      end
    end
  endfunction : dfp_pick

  function automatic logic [RPT_W-1:0] dfp_ret_last(input dfp_kind_t k);
    unique case (k)
      DFP_K_SC:  dfp_ret_last = RPT_W'(RET_SC_CYC - 1);
      DFP_K_UVS: dfp_ret_last = RPT_W'(RET_UVS_CYC - 1);
      DFP_K_UVP: dfp_ret_last = RPT_W'(RET_UVP_CYC - 1);
      DFP_K_OTH: dfp_ret_last = RPT_W'(RET_OTH_CYC - 1);
    endcase
  endfunction : dfp_ret_last

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    dfp_chan_t  n;
    logic       cmd;
    logic       ds;
    logic       blk;
    logic       hold;
    logic [3:0] ev;
    dfp_kind_t  k;
    n   = DFP_CHAN_RST;
    cmd = 1'b0;
    ds  = 1'b0;
    blk = 1'b0;
    hold = 1'b0;
    ev  = 4'h0;
    k   = DFP_K_SC;
    s_d = s_q;
    // two-stage synchronisers, edge history from the second stage only
    s_d.cmd_m  = cmd_i;
    s_d.cmd_s  = s_q.cmd_m;
    s_d.dsat_m = desat_i;
    s_d.dsat_s = s_q.dsat_m;
    s_d.uvs_m  = uv_sec_i;
    s_d.uvs_s  = s_q.uvs_m;
    s_d.uvs_p  = s_q.uvs_s;
    s_d.oth_m  = other_fault_i;
    s_d.oth_s  = s_q.oth_m;
    s_d.oth_p  = s_q.oth_s;
    s_d.uvp_m  = uv_pri_i;
    s_d.uvp_s  = s_q.uvp_m;
    s_d.uvp_p  = s_q.uvp_s;
    for (int c = 0; c < NCH; c++) begin
      n   = s_q.ch[c];
      cmd = s_q.cmd_s[c];
      ds  = s_q.dsat_s[c];
      blk = s_q.uvp_s | s_q.uvs_s[c];
      ev  = 4'h0;
      unique case (n.mode)
        DFP_OFF: begin
          n.tmr  = '0;
          n.filt = '0;
          if (cmd && !blk) begin
            n.mode = DFP_BLANK;
          end
        end
        DFP_BLANK: begin
          if (!cmd || blk) begin
            n.mode = DFP_OFF;
            n.tmr  = '0;
          end else if (n.tmr == BLANK_LAST) begin
            n.mode = DFP_SENSE;
            n.tmr  = '0;
          end else begin
            n.tmr = n.tmr + 1'b1;
          end
        end
        DFP_SENSE: begin
          if (!cmd || blk) begin
            n.mode = DFP_OFF;
            n.filt = '0;
          end else if (!ds) begin
            n.filt = '0;
          end else if (n.filt == FILT_LAST) begin
            n.mode    = DFP_SHUT;
            n.filt    = '0;
            ev[DFP_K_SC] = 1'b1;
          end else begin
            n.filt = n.filt + 1'b1;
          end
        end
        DFP_SHUT: begin
          if (n.tmr == BLOCK_LAST) begin
            n.mode = DFP_OFF;
            n.tmr  = '0;
          end else begin
            n.tmr = n.tmr + 1'b1;
          end
        end
      endcase
      // response age since turn-on, saturating; read by checks
      if (s_q.ch[c].mode == DFP_OFF) begin
        n.resp = '0;
      end else if (n.resp != '1) begin
        n.resp = n.resp + 1'b1;
      end
      // only a short selects the gradual path
      n.gate_on  = (n.mode == DFP_BLANK) || (n.mode == DFP_SENSE);
      n.soft_off = (n.mode == DFP_SHUT);
      n.clamp    = !n.gate_on;
      // fault events on rising edges
      ev[DFP_K_UVS] = s_q.uvs_s[c] & ~s_q.uvs_p[c];
      ev[DFP_K_UVP] = s_q.uvp_s & ~s_q.uvp_p;
      ev[DFP_K_OTH] = s_q.oth_s[c] & ~s_q.oth_p[c];
      if (n.busy) begin
        if (n.rpt == '0) begin
          n.busy = 1'b0;
        end else begin
          n.rpt = n.rpt - 1'b1;
        end
      end else if (|n.pend) begin
        k      = dfp_pick(n.pend);
        n.busy = 1'b1;
        n.kind = k;
        n.rpt  = dfp_ret_last(k);
        n.pend[k] = 1'b0;
      end
      // a new event is kept even if its bit is being consumed
      n.pend = n.pend | ev;
      // undervoltage holds low only while present
      // hold lags one stage so a short dip keeps the plain report length
      hold = s_q.uvp_p | s_q.uvs_p[c];
      n.fault_n = !(n.busy || hold);
      s_d.ch[c] = n;
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_q <= DFP_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_out
    assign gate_on_o[c]               = s_q.ch[c].gate_on;
    assign gradual_turn_off_o[c]      = s_q.ch[c].soft_off;
    assign collector_clamp_o[c]       = s_q.ch[c].clamp;
    assign fault_status_output_n_o[c] = s_q.ch[c].fault_n;
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking dfp_cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  for (genvar c = 0; c < NCH; c++) begin : g_chk
    own_path_a: assert property (
      $rose(s_q.ch[c].mode == DFP_SHUT) |->
        $past(s_q.dsat_s[c]) && $past(s_q.ch[c].filt) == FILT_LAST)
      else $error("shutdown without own channel filter");
    sc_off_a: assert property (
      s_q.ch[c].mode == DFP_SHUT |-> !gate_on_o[c])
      else $error("gate on during short shutdown");
    sc_flag_a: assert property (
      $rose(s_q.ch[c].mode == DFP_SHUT) && !s_q.ch[c].busy |->
        ##1 !fault_status_output_n_o[c])
      else $error("short not reported at once");
    block_hold_a: assert property (
      s_q.ch[c].mode == DFP_SHUT && s_q.ch[c].tmr != BLOCK_LAST |=>
        s_q.ch[c].mode == DFP_SHUT && !gate_on_o[c])
      else $error("blocking time cut short");
    blank_len_a: assert property (
      $rose(s_q.ch[c].mode == DFP_SENSE) |->
        $past(s_q.ch[c].tmr) == BLANK_LAST)
      else $error("blanking interval wrong length");
    filt_idle_a: assert property (
      s_q.ch[c].mode != DFP_SENSE |-> s_q.ch[c].filt == '0)
      else $error("filter counted while masked");
    filt_reset_a: assert property (
      s_q.ch[c].mode == DFP_SENSE && !s_q.dsat_s[c] |=>
        s_q.ch[c].filt == '0)
      else $error("filter not restarted by low comparator");
    min_resp_a: assert property (
      $rose(s_q.ch[c].mode == DFP_SHUT) |->
        $past(s_q.ch[c].resp) >= RESP_W'(MIN_RESP_CYC - 1))
      else $error("response faster than minimum");
    clamp_off_a: assert property (
      !s_q.cmd_s[c] |=> collector_clamp_o[c] && !gate_on_o[c])
      else $error("sense not clamped while off");
    ssd_use_a: assert property (
      $rose(s_q.ch[c].mode == DFP_SHUT) |-> gradual_turn_off_o[c])
      else $error("short without gradual turn-off");
    ssd_plain_a: assert property (
      $fell(gate_on_o[c]) && s_q.ch[c].mode != DFP_SHUT |->
        !gradual_turn_off_o[c])
      else $error("gradual turn-off on normal switching");
    ret_len_a: assert property (
      $rose(s_q.ch[c].busy) |->
        s_q.ch[c].rpt == dfp_ret_last(s_q.ch[c].kind) &&
        !fault_status_output_n_o[c])
      else $error("fault pulse length wrong");
    pri_uv_a: assert property (
      s_q.uvp_s && s_q.uvp_p |=>
        !gate_on_o[c] && !fault_status_output_n_o[c])
      else $error("primary undervoltage not handled");
    sec_uv_a: assert property (
      s_q.uvs_s[c] && s_q.uvs_p[c] |=>
        !gate_on_o[c] && !fault_status_output_n_o[c])
      else $error("secondary undervoltage not handled");
    uv_release_a: assert property (
      !s_q.uvp_p && !s_q.uvs_p[c] && !s_q.ch[c].busy &&
        s_q.ch[c].pend == 4'h0 |=> fault_status_output_n_o[c])
      else $error("status not released after undervoltage");
    pulse_keep_a: assert property (
      s_q.ch[c].busy && s_q.ch[c].rpt != '0 |=>
        s_q.ch[c].busy && $stable(s_q.ch[c].kind))
      else $error("report pulse cut by new fault");
    rpt_step_a: assert property (
      s_q.ch[c].busy && s_q.ch[c].rpt != '0 |=>
        s_q.ch[c].rpt == $past(s_q.ch[c].rpt) - 1'b1)
      else $error("report counter not counting cycles");
  end

endmodule : dfp_core

// ---- rtl/dfp_pkg.sv ----
package dfp_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned NCH           = 2;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned NS_PER_US     = 1000;
  localparam int unsigned NS_PER_MS     = 1000000;
  localparam int unsigned BLANK_TIME_NS = 3000;
  localparam int unsigned FILT_TIME_NS  = 1000;
  localparam int unsigned MIN_RESP_NS   = 4000;
  localparam int unsigned BLOCK_TIME_US = 100;
  localparam int unsigned RET_SC_MS     = 10;
  localparam int unsigned RET_UVS_MS    = 20;
  localparam int unsigned RET_UVP_MS    = 40;
  localparam int unsigned RET_OTH_MS    = 80;

  // least times round up to whole cycles
  localparam int unsigned BLANK_CYC =
    (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILT_CYC =
    (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_RESP_CYC =
    (MIN_RESP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLOCK_CYC_DEF =
    BLOCK_TIME_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int unsigned RET_SC_CYC_DEF  =
    RET_SC_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned RET_UVS_CYC_DEF =
    RET_UVS_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned RET_UVP_CYC_DEF =
    RET_UVP_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned RET_OTH_CYC_DEF =
    RET_OTH_MS * NS_PER_MS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // counter widths and terminal counts
  // ----------------------------------------------------------------------
  localparam int unsigned TMR_W  = 24;
  localparam int unsigned FILT_W = 8;
  localparam int unsigned RESP_W = 10;
  localparam int unsigned RPT_W  = 25;
  localparam logic [TMR_W-1:0]  BLANK_LAST = TMR_W'(BLANK_CYC - 1);
  localparam logic [FILT_W-1:0] FILT_LAST  = FILT_W'(FILT_CYC - 1);

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DFP_OFF   = 2'h0,
    DFP_BLANK = 2'h1,
    DFP_SENSE = 2'h3,
    DFP_SHUT  = 2'h2
  } dfp_mode_t;

  typedef enum logic [1:0] {
    DFP_K_SC  = 2'h0,
    DFP_K_UVS = 2'h1,
    DFP_K_UVP = 2'h2,
    DFP_K_OTH = 2'h3
  } dfp_kind_t;

  typedef struct packed {
    dfp_mode_t         mode;
    logic [TMR_W-1:0]  tmr;
    logic [FILT_W-1:0] filt;
    logic [RESP_W-1:0] resp;
    logic [3:0]        pend;
    logic              busy;
    dfp_kind_t         kind;
    logic [RPT_W-1:0]  rpt;
    logic              gate_on;
    logic              soft_off;
    logic              clamp;
    logic              fault_n;
  } dfp_chan_t;

  typedef struct packed {
    logic [NCH-1:0] cmd_m, cmd_s, dsat_m, dsat_s;
    logic [NCH-1:0] uvs_m, uvs_s, uvs_p, oth_m, oth_s, oth_p;
    logic           uvp_m, uvp_s, uvp_p;
    dfp_chan_t [NCH-1:0] ch;
  } dfp_state_t;

  // ----------------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------------
  localparam dfp_chan_t DFP_CHAN_RST = '{
    mode: DFP_OFF, kind: DFP_K_SC, clamp: 1'b1, fault_n: 1'b1, default: '0};
  localparam dfp_state_t DFP_STATE_RST = '{
    ch: '{DFP_CHAN_RST, DFP_CHAN_RST}, default: '0};

endpackage : dfp_pkg

// ---- dv/dfp_host_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// host side: measures each low report pulse in clock cycles
// ----------------------------------------------------------------------
module dfp_host_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // fault status lines, low while reporting
  input  wire logic [1:0]  fault_n_i,
  // one-cycle strobe with the measured low time
  output logic      [1:0]  done_o,
  output logic      [31:0] len_o [2]
);
  logic [31:0] cnt_q [2];

  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      done_o[c] <= 1'b0;
      if (srst_i) begin
        cnt_q[c] <= '0;
      end else if (fault_n_i[c] === 1'b0) begin
        cnt_q[c] <= cnt_q[c] + 1;
      end else if (cnt_q[c] != 0) begin
        done_o[c] <= 1'b1;
        len_o[c]  <= cnt_q[c];
        cnt_q[c]  <= '0;
      end
    end
  end
endmodule : dfp_host_model

// ---- dv/desat_fault_protection_tb_top.sv ----
`timescale 1ns/1ps

module desat_fault_protection_tb_top;
  import dfp_pkg::*;

  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic       clk;
  logic       srst;
  logic [1:0] cmd;
  logic [1:0] desat;
  logic       uvp;
  logic [1:0] uvs;
  logic [1:0] oth;
  logic       spare;
  logic [1:0] gate_on;
  logic [1:0] soft_off;
  logic [1:0] clamp;
  logic [1:0] fault_n;
  logic [1:0] hdone;
  logic [31:0] hlen [2];
  int         exp_q [2][$];
  int         bad_count;
  int         samples_checked;
  int         n;
  int         ev;
  int         r;
  integer     seed;

  // short counts keep the run small
  dfp_core #(.BLOCK_CYC(20), .RET_SC_CYC(40), .RET_UVS_CYC(60),
    .RET_UVP_CYC(80), .RET_OTH_CYC(100)) uut (
    .clk_i(clk), .srst_i(srst), .cmd_i(cmd), .desat_i(desat),
    .uv_pri_i(uvp), .uv_sec_i(uvs), .other_fault_i(oth),
    .unused_tie_i(spare), .gate_on_o(gate_on),
    .gradual_turn_off_o(soft_off), .collector_clamp_o(clamp),
    .fault_status_output_n_o(fault_n));

  dfp_host_model host (.clk_i(clk), .srst_i(srst), .fault_n_i(fault_n),
    .done_o(hdone), .len_o(hlen));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  function automatic logic pick(input int s, input int c);
    case (s)
      0: pick = gate_on[c];
      1: pick = soft_off[c];
      default: pick = fault_n[c];
    endcase
  endfunction : pick

  // bounded wait, returns cycles taken
  task automatic wait_for(input int s, input int c, input logic v,
                          input int lim, output int k);
    k = 0;
    do begin
      @(posedge clk);
      spare <= 1'($random(seed));
      #1;
      k++;
    end while (pick(s, c) !== v && k < lim);
  endtask : wait_for

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // every report pulse against the model queue; negative means at least
  always @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (hdone[c] === 1'b1) begin
        ev = (exp_q[c].size() != 0) ? exp_q[c].pop_front() : 0;
        if (ev < 0)
          check(32'(hlen[c] >= 32'(-ev)), 32'h1);
        else
          check(hlen[c], 32'(ev));
      end
    end
  end

  // ----------------------------------------------------------------------
  // clock, watchdog
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    give_verdict;
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    seed = 32'h4218fe16;
    srst = 1'b1;
    {cmd, desat, uvs, oth} = '0;
    uvp = 1'b0;
    spare = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check({gate_on, soft_off, clamp, fault_n}, 8'h0f);
    @(posedge clk);
    srst <= 1'b0;
    $display("test reset done");
    // short on ch0 with desat high from turn-on, ch1 runs clean
    @(posedge clk);
    cmd <= 2'h3;
    desat <= 2'h1;
    exp_q[0].push_back(40);
    wait_for(0, 0, 1, 10, n);
    check(clamp[0], 1'b0);
    wait_for(0, 0, 0, 1100, n);
    check(32'(n >= 1000 && n <= 1005), 32'h1);
    check({soft_off[0], clamp[0]}, 2'h3);
    check({gate_on[1], soft_off[1]}, 2'h2);
    @(posedge clk);
    desat <= 2'h0;
    wait_for(2, 0, 0, 6, n);
    check(32'(n <= 3), 32'h1);
    wait_for(0, 0, 1, 40, n);
    check(32'(n >= 18 && n <= 24), 32'h1);
    check(fault_n[1], 1'b1);
    $display("test short done");
    // filter restart on broken desat, then a full trip
    repeat (760) @(posedge clk);
    for (int g = 0; g < 3; g++) begin
      r = 10 + ($random(seed) & 32'h7f);
      desat <= {1'($random(seed)), 1'b1};
      repeat (r) @(posedge clk);
      desat <= 2'h0;
      repeat (3) @(posedge clk);
    end
    #1;
    check({gate_on[0], soft_off[0]}, 2'h2);
    @(posedge clk);
    desat <= 2'h1;
    exp_q[0].push_back(40);
    wait_for(1, 0, 1, 300, n);
    check(32'(n >= 250 && n <= 256), 32'h1);
    @(posedge clk);
    desat <= 2'h0;
    cmd[0] <= 1'b0;
    $display("test filter done");
    // ordinary turn-off of ch1
    @(posedge clk);
    cmd[1] <= 1'b0;
    wait_for(0, 1, 0, 8, n);
    check({gate_on[1], soft_off[1], clamp[1]}, 3'h1);
    repeat (100) @(posedge clk);
    $display("test plain off done");
    // other, secondary and primary report kinds once each
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      case (k)
        0: begin
          r = $random(seed);
          oth <= 2'h1 << r[0];
          exp_q[r[0]].push_back(100);
        end
        1: begin
          r = $random(seed);
          uvs <= 2'h1 << r[0];
          exp_q[r[0]].push_back(60);
        end
        default: begin
          uvp <= 1'b1;
          exp_q[0].push_back(80);
          exp_q[1].push_back(80);
        end
      endcase
      repeat (2) @(posedge clk);
      {oth, uvs} <= '0;
      uvp <= 1'b0;
      repeat (120) @(posedge clk);
    end
    $display("test codes done");
    // second event during a running pulse waits its turn
    @(posedge clk);
    oth[1] <= 1'b1;
    exp_q[1].push_back(100);
    exp_q[1].push_back(60);
    repeat (10) @(posedge clk);
    uvs[1] <= 1'b1;
    oth[1] <= 1'b0;
    repeat (2) @(posedge clk);
    uvs[1] <= 1'b0;
    repeat (200) @(posedge clk);
    $display("test queued done");
    // long undervoltage holds, blocks and releases
    @(posedge clk);
    cmd <= 2'h3;
    repeat (10) @(posedge clk);
    uvp <= 1'b1;
    exp_q[0].push_back(-80);
    exp_q[1].push_back(-80);
    repeat (10) @(posedge clk);
    #1;
    check({gate_on, fault_n}, 4'h0);
    repeat (190) @(posedge clk);
    uvp <= 1'b0;
    wait_for(2, 0, 1, 12, n);
    check(32'(n < 12), 32'h1);
    repeat (20) @(posedge clk);
    uvs[1] <= 1'b1;
    exp_q[1].push_back(-60);
    repeat (20) @(posedge clk);
    #1;
    check({gate_on, fault_n}, 4'h5);
    repeat (200) @(posedge clk);
    uvs[1] <= 1'b0;
    repeat (150) @(posedge clk);
    check(32'(exp_q[0].size() + exp_q[1].size()), 32'h0);
    $display("test undervoltage done");
    give_verdict;
  end
endmodule : desat_fault_protection_tb_top
